// >>> verif/adc_conversion_control_bench.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module adc_conversion_control_bench;
	logic                   mclk = 1'b0;
	logic                   reset = 1'b1;
	adc_ctrl_pkg::bus_req_t req = '0;
	logic                   hw = 1'b0;
	logic                   stop = 1'b0;
	logic                   alt, tick, aen, smp, apx, act, lpc, irq;
	logic [9:0]             ares;
	logic [7:0]             rd_data;
	logic [4:0]             ch;
	int                     errors = 0;
	int                     comparisons = 0;
	int                     cycles = 0;

	always #25 mclk = ~mclk;

	adc_conversion_control i_dut (.mclk(mclk), .reset(reset), .bus_req(req), .rd_data(rd_data),
		.hw_trigger_input(hw), .alternate_clock(alt), .async_clock_tick(tick), .stop_request(stop),
		.analog_result(ares), .async_clock_enable(aen), .sample_active(smp), .approx_active(apx),
		.conversion_active(act), .low_power_select(lpc), .channel_select(ch), .complete_irq(irq));
	sar_core_model i_core (.mclk(mclk), .reset(reset), .async_clock_enable(aen), .approx_active(apx),
		.alternate_clock(alt), .async_clock_tick(tick), .analog_result(ares));

	task automatic summarize;
		if (errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			$display("ERROR %0t timeout", $time);
			summarize();
		end
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one bus cycle; on return a read's data stands on rd_data
	task automatic cyc(input logic [2:0] a, input logic [7:0] d, input logic w);
		@(posedge mclk);
		req <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge mclk);
		req <= '0;
		#1;
	endtask

	task automatic wait_idle(input int lim);
		for (int n = 0; n < lim && act === 1'b1; n++) begin
			@(posedge mclk);
			#1;
		end
		check(act, 8'h00);
	endtask

	task automatic t_single;
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h00, 1'b0);
		check(rd_data, 8'h1F);
		cyc(3'h7, 8'h00, 1'b0);
		check(rd_data, 8'h00);
		cyc(adc_ctrl_pkg::OFS_CFG, 8'h00, 1'b1);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h41, 1'b1);
		check(act, 8'h01);
		wait_idle(26);
		check(irq, 8'h01);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h00, 1'b0);
		check(rd_data, 8'hC1);
		cyc(adc_ctrl_pkg::OFS_RL, 8'h00, 1'b0);
		check(rd_data, 8'hA9);
		check(irq, 8'h00);
	endtask

	task automatic t_abort;
		logic [2:0] regs[4];
		regs = '{adc_ctrl_pkg::OFS_SC2, adc_ctrl_pkg::OFS_CFG, adc_ctrl_pkg::OFS_CVH, adc_ctrl_pkg::OFS_CVL};
		foreach (regs[i]) begin
			cyc(adc_ctrl_pkg::OFS_SC1, 8'h01, 1'b1);
			cyc(regs[i], 8'h00, 1'b1);
			check(act, 8'h00);
		end
		cyc(adc_ctrl_pkg::OFS_RL, 8'h00, 1'b0);
		check(rd_data, 8'hA9);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h01, 1'b1);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h1F, 1'b1);
		check({2'b00, act, ch}, 8'h1F);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h01, 1'b1);
		@(posedge mclk);
		stop <= 1'b1;
		@(posedge mclk);
		stop <= 1'b0;
		#1;
		check(act, 8'h00);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h01, 1'b1);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h01, 1'b1);
		check(act, 8'h01);
		wait_idle(26);
	endtask

	task automatic t_hw;
		cyc(adc_ctrl_pkg::OFS_SC2, 8'h40, 1'b1);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h01, 1'b1);
		check(act, 8'h00);
		@(posedge mclk);
		hw <= 1'b1;
		repeat (3) @(posedge mclk);
		hw <= 1'b0;
		#1;
		check(act, 8'h01);
		@(posedge mclk);
		hw <= 1'b1;
		wait_idle(26);
		repeat (4) @(posedge mclk);
		#1;
		check(act, 8'h00);
		@(posedge mclk);
		hw <= 1'b0;
		cyc(adc_ctrl_pkg::OFS_SC2, 8'h00, 1'b1);
	endtask

	task automatic t_cont;
		int  r;
		logic p;
		r = 0;
		p = 1'b0;
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h21, 1'b1);
		repeat (80) begin
			@(posedge mclk);
			#1;
			r += (smp && !p) ? 1 : 0;
			p = smp;
		end
		check(act, 8'h01);
		check(8'(r), 8'h05);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h1F, 1'b1);
	endtask

	task automatic t_cmp;
		cyc(adc_ctrl_pkg::OFS_CVL, 8'hFF, 1'b1);
		cyc(adc_ctrl_pkg::OFS_SC2, 8'h30, 1'b1);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h01, 1'b1);
		wait_idle(26);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h00, 1'b0);
		check(rd_data, 8'h01);
		cyc(adc_ctrl_pkg::OFS_RL, 8'h00, 1'b0);
		check(rd_data, 8'hA9);
		cyc(adc_ctrl_pkg::OFS_SC2, 8'h20, 1'b1);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h01, 1'b1);
		wait_idle(26);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h00, 1'b0);
		check(rd_data, 8'h81);
		cyc(adc_ctrl_pkg::OFS_RL, 8'h00, 1'b0);
		check(rd_data, 8'hAA);
		cyc(adc_ctrl_pkg::OFS_SC2, 8'h00, 1'b1);
	endtask

	task automatic t_block;
		cyc(adc_ctrl_pkg::OFS_CFG, 8'h08, 1'b1);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h01, 1'b1);
		wait_idle(29);
		cyc(adc_ctrl_pkg::OFS_RH, 8'h00, 1'b0);
		check(rd_data, 8'h02);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h01, 1'b1);
		repeat (40) @(posedge mclk);
		#1;
		check(act, 8'h01);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h00, 1'b0);
		check(rd_data, 8'h01);
		cyc(adc_ctrl_pkg::OFS_RL, 8'h00, 1'b0);
		check(rd_data, 8'hA5);
		wait_idle(22);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h00, 1'b0);
		check(rd_data, 8'h81);
	endtask

	task automatic t_async;
		cyc(adc_ctrl_pkg::OFS_CFG, 8'h83, 1'b1);
		check(lpc, 8'h01);
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h01, 1'b1);
		check(aen, 8'h01);
		wait_idle(150);
		check(aen, 8'h00);
	endtask

	// half bus clock divided by two, then the alternate source: 20 ticks of four cycles each
	task automatic t_clk;
		logic [7:0] cfgs[2];
		cfgs = '{8'h21, 8'h02};
		foreach (cfgs[i]) begin
			cyc(adc_ctrl_pkg::OFS_CFG, cfgs[i], 1'b1);
			cyc(adc_ctrl_pkg::OFS_SC1, 8'h01, 1'b1);
			repeat (80) @(posedge mclk);
			#1;
			check(act, 8'h01);
			wait_idle(6);
		end
	endtask

	// reset in mid-conversion clears the results as well
	task automatic t_reset;
		cyc(adc_ctrl_pkg::OFS_SC1, 8'h01, 1'b1);
		repeat (10) @(posedge mclk);
		reset <= 1'b1;
		@(posedge mclk);
		reset <= 1'b0;
		#1;
		check(act, 8'h00);
		check(ch, 8'h1F);
		cyc(adc_ctrl_pkg::OFS_RL, 8'h00, 1'b0);
		check(rd_data, 8'h00);
	endtask

	initial begin
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		#1;
		check(ch, 8'h1F);
		t_single();
		t_abort();
		t_hw();
		t_cont();
		t_cmp();
		t_block();
		t_async();
		t_clk();
		t_reset();
		summarize();
	end
endmodule

// >>> verif/adc_ctrl_monitor.sv
// port assertions for the conversion control block
`timescale 1ns/1ps
module adc_ctrl_monitor (
	input wire logic                   mclk,
	input wire logic                   reset,
	input wire adc_ctrl_pkg::bus_req_t bus_req,
	input wire logic [7:0]             rd_data,
	input wire logic                   hw_trigger_input,
	input wire logic                   stop_request,
	input wire logic                   async_clock_enable,
	input wire logic                   sample_active,
	input wire logic                   approx_active,
	input wire logic                   conversion_active,
	input wire logic [4:0]             channel_select
);
	logic                trg_q;
	adc_ctrl_pkg::cfg_t  cfg_q;
	wire                 wr_sc1 = bus_req.wr && bus_req.addr == adc_ctrl_pkg::OFS_SC1;
	wire                 wr_mode = bus_req.wr && (bus_req.addr == adc_ctrl_pkg::OFS_SC2 ||
		bus_req.addr == adc_ctrl_pkg::OFS_CFG || bus_req.addr == adc_ctrl_pkg::OFS_CVH ||
		bus_req.addr == adc_ctrl_pkg::OFS_CVL);
	wire                 fast = cfg_q.iclk == adc_ctrl_pkg::ICLK_BUS && cfg_q.div == 2'h0 && !cfg_q.lsmp;

	// shadow of the trigger select and configuration, as software last wrote them
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			trg_q <= 1'b0;
			cfg_q <= adc_ctrl_pkg::CFG_RESET;
		end else if (bus_req.wr && bus_req.addr == adc_ctrl_pkg::OFS_SC2) begin
			trg_q <= bus_req.wdata[6];
		end else if (bus_req.wr && bus_req.addr == adc_ctrl_pkg::OFS_CFG) begin
			cfg_q <= bus_req.wdata;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	sequence s_short_start;
		$rose(sample_active) && fast;
	endsequence
	sequence s_short_hold;
		sample_active [*4] ##1 !sample_active;
	endsequence

	property p_sw_start;
		wr_sc1 && bus_req.wdata[4:0] != adc_ctrl_pkg::CHANNEL_OFF && !trg_q |=> conversion_active;
	endproperty
	property p_ch_off;
		wr_sc1 && bus_req.wdata[4:0] == adc_ctrl_pkg::CHANNEL_OFF |=> !conversion_active &&
			channel_select == adc_ctrl_pkg::CHANNEL_OFF;
	endproperty
	property p_mode_abort;
		wr_mode |=> !conversion_active;
	endproperty
	property p_stop_abort;
		stop_request && cfg_q.iclk != adc_ctrl_pkg::ICLK_ASYNC |=> !conversion_active;
	endproperty
	property p_async_gate;
		async_clock_enable |-> cfg_q.iclk == adc_ctrl_pkg::ICLK_ASYNC;
	endproperty
	property p_hw_start;
		trg_q && !conversion_active && channel_select != adc_ctrl_pkg::CHANNEL_OFF &&
			$rose(hw_trigger_input) && !bus_req.wr |-> ##[1:2] conversion_active;
	endproperty
	property p_sample_len;
		s_short_start |-> s_short_hold;
	endproperty
	property p_phase_excl;
		!(sample_active && approx_active);
	endproperty
	property p_active_ch;
		conversion_active |-> channel_select != adc_ctrl_pkg::CHANNEL_OFF;
	endproperty

	a_sw_start: assert property (p_sw_start) else $error("write did not start conversion");
	a_ch_off: assert property (p_ch_off) else $error("channel off did not stop converter");
	a_mode_abort: assert property (p_mode_abort) else $error("mode write did not abort");
	a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort");
	a_async_gate: assert property (p_async_gate) else $error("async clock enabled wrongly");
	a_hw_start: assert property (p_hw_start) else $error("trigger edge did not start");
	a_sample_len: assert property (p_sample_len) else $error("short sample length wrong");
	a_phase_excl: assert property (p_phase_excl) else $error("sample and approx overlap");
	a_active_ch: assert property (p_active_ch) else $error("active with channel off");
endmodule

bind adc_conversion_control adc_ctrl_monitor i_mon (
	.mclk(mclk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
	.hw_trigger_input(hw_trigger_input), .stop_request(stop_request),
	.async_clock_enable(async_clock_enable), .sample_active(sample_active),
	.approx_active(approx_active), .conversion_active(conversion_active), .channel_select(channel_select)
);

// >>> verif/sar_core_model.sv
// behavioural analog core and clock sources on the converter's far side
`timescale 1ns/1ps
module sar_core_model #(
	parameter logic [9:0] CODE = 10'h2A5
) (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       async_clock_enable,
	input  wire logic       approx_active,
	output logic            alternate_clock,
	output logic            async_clock_tick,
	output logic [9:0]      analog_result
);
	logic       ph_q;
	logic [1:0] alt_cnt_q;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ph_q      <= 1'b0;
			alt_cnt_q <= 2'h0;
		end else begin
			ph_q      <= async_clock_enable ? ~ph_q : 1'b0;
			alt_cnt_q <= alt_cnt_q + 2'h1;
		end
	end
	assign async_clock_tick = async_clock_enable && ph_q;
	// alternate source runs free, one rising edge every four bus cycles
	assign alternate_clock = alt_cnt_q[1];
	// outside approximation the core output is not valid, so show the inverse
	assign analog_result = approx_active ? CODE : ~CODE;
endmodule

// >>> verilog/adc_conversion_control.sv
// conversion sequencing, abort, blocking and compare logic of the converter
// Behaviour
// - software trigger: write to control one with channel not all ones starts conversion.
// - hardware trigger selected: trigger event starts a conversion.
// - continuous mode relaunches right after each result transfer.
// - continuous series starts on one write or one trigger, repeats until aborted.
// - completion is the result transfer; flag set, interrupt if enable high.
// - 10-bit mode, high read but low not: transfer blocked, flag clear, result lost.
// - single conversion, compare enabled and false: blocking ignored, converter stops.
// - any other blocked transfer starts another conversion, single or continuous.
// - write to control one aborts; restarts unless channel all ones or hardware trigger selected.
// - write to control two, configuration or compare values aborts conversion.
// - reset aborts; stop entry aborts unless asynchronous clock selected.
// - abort keeps last results; reset returns results to reset values.
// - idle until started; async clock generator enabled only while active.
// - sample short or long, then approximate, then transfer result.
// - first conversion: 20/23/40/43 conversion clocks plus 5 bus cycles.
// - asynchronous clock adds 5 us startup to the first conversion.
// - later continuous conversions: 17/20/37/40 conversion clocks.
// - compare adds negated compare value; flag on greater-equal or less-than.
// - compare true stores the sum; false stores nothing, flag stays clear.
// - wait mode lets conversions run, start and complete with interrupt.
// - bus, half bus and async clocks stay usable in wait mode.
// - converter disabled during reset and while channel is all ones.
// - trigger rising edge starts; edges during conversion or continuous ignored.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps

module adc_conversion_control (
	input  wire logic                  mclk,
	input  wire logic                  reset,
	input  wire adc_ctrl_pkg::bus_req_t bus_req,
	output logic [7:0]                 rd_data,
	input  wire logic                  hw_trigger_input,
	input  wire logic                  alternate_clock,
	input  wire logic                  async_clock_tick,
	input  wire logic                  stop_request,
	input  wire logic [9:0]            analog_result,
	output logic                       async_clock_enable,
	output logic                       sample_active,
	output logic                       approx_active,
	output logic                       conversion_active,
	output logic                       low_power_select,
	output logic [4:0]                 channel_select,
	output logic                       complete_irq
);

	adc_ctrl_pkg::state_t state_q;
	adc_ctrl_pkg::state_t state_d;
	adc_ctrl_pkg::sc2_t   sc2_q;
	adc_ctrl_pkg::cfg_t   cfg_q;
	adc_ctrl_pkg::sc1_t   sc1_w;

	logic       complete_irq_enable_q;
	logic       continuous_enable_q;
	logic [4:0] ch_q;
	logic       conversion_complete_flag_q;
	logic       conversion_complete_flag_d;
	logic       hi_read_q;
	logic [7:0] cvh_q;
	logic [7:0] cvl_q;
	logic [7:0] rh_q;
	logic [7:0] rl_q;
	logic       trig_q;
	logic       alt_q;
	logic       half_q;
	logic [2:0] div_cnt_q;
	logic [6:0] cnt_q;
	logic [6:0] cnt_d;

	// register decode
	wire wr_sc1 = bus_req.wr && (bus_req.addr == adc_ctrl_pkg::OFS_SC1);
	wire wr_sc2 = bus_req.wr && (bus_req.addr == adc_ctrl_pkg::OFS_SC2);
	wire wr_cfg = bus_req.wr && (bus_req.addr == adc_ctrl_pkg::OFS_CFG);
	wire wr_cvh = bus_req.wr && (bus_req.addr == adc_ctrl_pkg::OFS_CVH);
	wire wr_cvl = bus_req.wr && (bus_req.addr == adc_ctrl_pkg::OFS_CVL);
	wire rd_rh  = bus_req.rd && (bus_req.addr == adc_ctrl_pkg::OFS_RH);
	wire rd_rl  = bus_req.rd && (bus_req.addr == adc_ctrl_pkg::OFS_RL);

	assign sc1_w = adc_ctrl_pkg::sc1_t'(bus_req.wdata);

	wire ten_bit = cfg_q.mode == adc_ctrl_pkg::MODE_10BIT;
	wire ch_off  = ch_q == adc_ctrl_pkg::CHANNEL_OFF;
	wire idle    = state_q == adc_ctrl_pkg::ST_IDLE;
	wire async_sel = cfg_q.iclk == adc_ctrl_pkg::ICLK_ASYNC;

	// start and abort sources
	wire mode_change = wr_sc2 || wr_cfg || wr_cvh || wr_cvl;
	wire stop_abort  = stop_request && !async_sel;
	wire sw_start    = wr_sc1 && (sc1_w.ch != adc_ctrl_pkg::CHANNEL_OFF) && !sc2_q.trg;
	wire hw_edge     = hw_trigger_input && !trig_q;
	// edges are only looked at while idle, so a running series ignores them
	wire hw_start    = sc2_q.trg && hw_edge && idle && !ch_off;

	// conversion clock source and divider
	logic src_tick;
	always_comb begin
		case (cfg_q.iclk)
			adc_ctrl_pkg::ICLK_BUS:      src_tick = 1'b1;
			adc_ctrl_pkg::ICLK_BUS_HALF: src_tick = half_q;
			adc_ctrl_pkg::ICLK_ALT:      src_tick = alternate_clock && !alt_q;
			default:                     src_tick = async_clock_tick;
		endcase
	end
	// wait mode has no effect here: every source keeps ticking

	wire [2:0] div_max = (cfg_q.div == 2'h0) ? 3'h0 :
	                     (cfg_q.div == 2'h1) ? 3'h1 :
	                     (cfg_q.div == 2'h2) ? 3'h3 : 3'h7;
	wire running = (state_q == adc_ctrl_pkg::ST_SETUP) ||
	               (state_q == adc_ctrl_pkg::ST_SAMPLE) ||
	               (state_q == adc_ctrl_pkg::ST_APPROX);
	wire conversion_clock_en = running && src_tick && (div_cnt_q == div_max);

	// phase lengths
	wire [6:0] startup_len = adc_ctrl_pkg::STARTUP_BUS_CYC +
		(async_sel ? 7'(adc_ctrl_pkg::ASYNC_STARTUP_CYC) : 7'h00);
	wire [6:0] sample_len = cfg_q.lsmp ? adc_ctrl_pkg::SAMPLE_LONG_CONVERSION_CLOCK :
	                                     adc_ctrl_pkg::SAMPLE_SHORT_CONVERSION_CLOCK;
	wire [6:0] approx_len = ten_bit ? adc_ctrl_pkg::APPROX_10BIT_CONVERSION_CLOCK :
	                                  adc_ctrl_pkg::APPROX_8BIT_CONVERSION_CLOCK;

	logic [6:0] phase_len;
	always_comb begin
		case (state_q)
			adc_ctrl_pkg::ST_STARTUP: phase_len = startup_len;
			adc_ctrl_pkg::ST_SETUP:   phase_len = adc_ctrl_pkg::SETUP_CONVERSION_CLOCK;
			adc_ctrl_pkg::ST_SAMPLE:  phase_len = sample_len;
			default:                  phase_len = approx_len;
		endcase
	end

	// startup counts bus cycles, later phases count conversion clocks
	wire phase_tick = (state_q == adc_ctrl_pkg::ST_STARTUP) || conversion_clock_en;
	wire phase_last = phase_tick && (cnt_q == phase_len - 7'h01);
	wire conv_done  = (state_q == adc_ctrl_pkg::ST_APPROX) && phase_last;

	// compare and result shaping
	wire [9:0]  res_raw = ten_bit ? analog_result : {2'h0, analog_result[9:2]};
	wire [9:0]  cmp_val = ten_bit ? {cvh_q[1:0], cvl_q} : {2'h0, cvl_q};
	wire [10:0] cmp_sum = {1'b0, res_raw} + {1'b0, ~cmp_val} + 11'h001;
	wire        cmp_ge  = cmp_sum[10];
	wire        cmp_ok  = sc2_q.compare_greater_select ? cmp_ge : !cmp_ge;
	wire        cmp_fail = sc2_q.compare_function_enable && !cmp_ok;
	wire [9:0]  xfer_val = sc2_q.compare_function_enable ? cmp_sum[9:0] : res_raw;

	wire blocked     = ten_bit && hi_read_q;
	wire stop_single = cmp_fail && !continuous_enable_q;
	wire do_xfer     = conv_done && !cmp_fail && !blocked;
	// blocked transfers retry regardless of continuous mode
	wire restart     = !stop_single && (blocked || continuous_enable_q);

	// sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			adc_ctrl_pkg::ST_IDLE: begin
				if (hw_start)
					state_d = adc_ctrl_pkg::ST_STARTUP;
			end
			adc_ctrl_pkg::ST_STARTUP: begin
				if (phase_last)
					state_d = adc_ctrl_pkg::ST_SETUP;
			end
			adc_ctrl_pkg::ST_SETUP: begin
				if (phase_last)
					state_d = adc_ctrl_pkg::ST_SAMPLE;
			end
			adc_ctrl_pkg::ST_SAMPLE: begin
				if (phase_last)
					state_d = adc_ctrl_pkg::ST_APPROX;
			end
			adc_ctrl_pkg::ST_APPROX: begin
				if (conv_done)
					state_d = restart ? adc_ctrl_pkg::ST_SAMPLE : adc_ctrl_pkg::ST_IDLE;
			end
			default: state_d = adc_ctrl_pkg::ST_IDLE;
		endcase
		if (mode_change || stop_abort || ch_off)
			state_d = adc_ctrl_pkg::ST_IDLE;
		if (wr_sc1)
			state_d = sw_start ? adc_ctrl_pkg::ST_STARTUP : adc_ctrl_pkg::ST_IDLE;
	end

	always_comb begin
		if (state_d != state_q || wr_sc1)
			cnt_d = 7'h00;
		else if (phase_tick)
			cnt_d = cnt_q + 7'h01;
		else
			cnt_d = cnt_q;
	end

	// a new result sets the flag even if a clear arrives in the same cycle
	wire conversion_complete_flag_clr = wr_sc1 || rd_rl;
	assign conversion_complete_flag_d = do_xfer ? 1'b1 : (conversion_complete_flag_clr ? 1'b0 : conversion_complete_flag_q);
	wire complete_irq_enable_d = wr_sc1 ? sc1_w.complete_irq_enable : complete_irq_enable_q;

	// read data
	wire [7:0] sc1_rd = {conversion_complete_flag_q, complete_irq_enable_q, continuous_enable_q, ch_q};
	wire [7:0] sc2_rd = {!idle, sc2_q.trg, sc2_q.compare_function_enable, sc2_q.compare_greater_select, 4'h0};
	wire [7:0] rd_mux = (bus_req.addr == adc_ctrl_pkg::OFS_SC1) ? sc1_rd :
	                    (bus_req.addr == adc_ctrl_pkg::OFS_SC2) ? sc2_rd :
	                    (bus_req.addr == adc_ctrl_pkg::OFS_RH)  ? rh_q :
	                    (bus_req.addr == adc_ctrl_pkg::OFS_RL)  ? rl_q :
	                    (bus_req.addr == adc_ctrl_pkg::OFS_CVH) ? cvh_q :
	                    (bus_req.addr == adc_ctrl_pkg::OFS_CVL) ? cvl_q :
	                    (bus_req.addr == adc_ctrl_pkg::OFS_CFG) ? cfg_q : 8'h00;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_q   <= adc_ctrl_pkg::ST_IDLE;
			cnt_q     <= 7'h00;
			div_cnt_q <= 3'h0;
			half_q    <= 1'b0;
			alt_q     <= 1'b0;
			trig_q    <= 1'b0;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			div_cnt_q <= (!running || (src_tick && div_cnt_q == div_max)) ? 3'h0 :
			             (src_tick ? div_cnt_q + 3'h1 : div_cnt_q);
			half_q    <= !half_q;
			alt_q     <= alternate_clock;
			trig_q    <= hw_trigger_input;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			complete_irq_enable_q <= 1'b0;
			continuous_enable_q <= 1'b0;
			ch_q   <= adc_ctrl_pkg::CHANNEL_OFF;
			sc2_q  <= adc_ctrl_pkg::sc2_t'(adc_ctrl_pkg::SC2_RESET);
			cfg_q  <= adc_ctrl_pkg::cfg_t'(adc_ctrl_pkg::CFG_RESET);
			cvh_q  <= adc_ctrl_pkg::CV_RESET;
			cvl_q  <= adc_ctrl_pkg::CV_RESET;
		end else begin
			if (wr_sc1) begin
				complete_irq_enable_q <= sc1_w.complete_irq_enable;
				continuous_enable_q <= sc1_w.continuous_enable;
				ch_q   <= sc1_w.ch;
			end
			if (wr_sc2)
				sc2_q <= adc_ctrl_pkg::sc2_t'({1'b0, bus_req.wdata[6:4], 4'h0});
			if (wr_cfg)
				cfg_q <= adc_ctrl_pkg::cfg_t'(bus_req.wdata);
			if (wr_cvh)
				cvh_q <= bus_req.wdata;
			if (wr_cvl)
				cvl_q <= bus_req.wdata;
		end
	end

	// results change only on a transfer; aborts leave them alone
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rh_q      <= adc_ctrl_pkg::RESULT_RESET;
			rl_q      <= adc_ctrl_pkg::RESULT_RESET;
			conversion_complete_flag_q    <= 1'b0;
			hi_read_q <= 1'b0;
		end else begin
			if (do_xfer) begin
				rh_q <= ten_bit ? {6'h00, xfer_val[9:8]} : 8'h00;
				rl_q <= xfer_val[7:0];
			end
			conversion_complete_flag_q <= conversion_complete_flag_d;
			// early high read during a single conversion causes retries
			if (rd_rh && ten_bit)
				hi_read_q <= 1'b1;
			else if (rd_rl)
				hi_read_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rd_data            <= 8'h00;
			async_clock_enable <= 1'b0;
			sample_active      <= 1'b0;
			approx_active      <= 1'b0;
			conversion_active  <= 1'b0;
			low_power_select   <= 1'b0;
			channel_select     <= adc_ctrl_pkg::CHANNEL_OFF;
			complete_irq       <= 1'b0;
		end else begin
			rd_data            <= bus_req.rd ? rd_mux : 8'h00;
			async_clock_enable <= (state_d != adc_ctrl_pkg::ST_IDLE) &&
			                      ((wr_cfg ? bus_req.wdata[1:0] : cfg_q.iclk) ==
			                       adc_ctrl_pkg::ICLK_ASYNC);
			sample_active      <= state_d == adc_ctrl_pkg::ST_SAMPLE;
			approx_active      <= state_d == adc_ctrl_pkg::ST_APPROX;
			conversion_active  <= state_d != adc_ctrl_pkg::ST_IDLE;
			low_power_select   <= wr_cfg ? bus_req.wdata[7] : cfg_q.lpc;
			channel_select     <= wr_sc1 ? sc1_w.ch : ch_q;
			complete_irq       <= conversion_complete_flag_d && complete_irq_enable_d;
		end
	end

endmodule

// >>> verilog/adc_ctrl_pkg.sv
// constants, register map and types shared by the conversion control block
package adc_ctrl_pkg;

	// register index on the plain register port
	localparam logic [2:0] OFS_SC1 = 3'h0;
	localparam logic [2:0] OFS_SC2 = 3'h1;
	localparam logic [2:0] OFS_RH  = 3'h2;
	localparam logic [2:0] OFS_RL  = 3'h3;
	localparam logic [2:0] OFS_CVH = 3'h4;
	localparam logic [2:0] OFS_CVL = 3'h5;
	localparam logic [2:0] OFS_CFG = 3'h6;

	// reset values
	localparam logic [4:0] CHANNEL_OFF  = 5'h1F;
	localparam logic [7:0] SC2_RESET    = 8'h00;
	localparam logic [7:0] CFG_RESET    = 8'h00;
	localparam logic [7:0] CV_RESET     = 8'h00;
	localparam logic [7:0] RESULT_RESET = 8'h00;

	// field encodings
	localparam logic [1:0] MODE_10BIT    = 2'h2;
	localparam logic [1:0] ICLK_BUS      = 2'h0;
	localparam logic [1:0] ICLK_BUS_HALF = 2'h1;
	localparam logic [1:0] ICLK_ALT      = 2'h2;
	localparam logic [1:0] ICLK_ASYNC    = 2'h3;

	// timing
	localparam int         CLK_MHZ            = 20;
	localparam int         ASYNC_STARTUP_NS   = 5000;
	localparam int         ASYNC_STARTUP_CYC  = (ASYNC_STARTUP_NS * CLK_MHZ + 999) / 1000;
	localparam logic [6:0] STARTUP_BUS_CYC    = 7'h05;
	localparam logic [6:0] SETUP_CONVERSION_CLOCK         = 7'h03;
	localparam logic [6:0] SAMPLE_SHORT_CONVERSION_CLOCK  = 7'h04;
	localparam logic [6:0] SAMPLE_LONG_CONVERSION_CLOCK   = 7'h18;
	localparam logic [6:0] APPROX_8BIT_CONVERSION_CLOCK   = 7'h0D;
	localparam logic [6:0] APPROX_10BIT_CONVERSION_CLOCK  = 7'h10;

	typedef struct packed {
		logic       conversion_complete_flag;
		logic       complete_irq_enable;
		logic       continuous_enable;
		logic [4:0] ch;
	} sc1_t;

	typedef struct packed {
		logic       active;
		logic       trg;
		logic       compare_function_enable;
		logic       compare_greater_select;
		logic [3:0] rsvd;
	} sc2_t;

	typedef struct packed {
		logic       lpc;
		logic [1:0] div;
		logic       lsmp;
		logic [1:0] mode;
		logic [1:0] iclk;
	} cfg_t;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_STARTUP = 3'b001,
		ST_SETUP   = 3'b010,
		ST_SAMPLE  = 3'b011,
		ST_APPROX  = 3'b100
	} state_t;

endpackage
